// >>> include/trig_map.svh
// Constants for the acquisition trigger control block.
// Assumes inclusion by the design file only.
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH
// Register byte offsets
`define TRIG_CTRL_OFS 8'h00
`define TRIG_LEVEL_OFS 8'h04
`define TRIG_RANGE_OFS 8'h08
`define TRIG_OFFSET_OFS 8'h0C
`define TRIG_DELAY_OFS 8'h10
`define TRIG_STEP_OFS 8'h14
`define TRIG_WINDOW_OFS 8'h18
`define TRIG_READOUT_OFS 8'h1C
`define TRIG_STATUS_OFS 8'h20
// Control field positions
`define CTRL_SRC_LSB 0
`define CTRL_SLOPE_BIT 5
`define CTRL_COUP_BIT 6
`define CTRL_UNIT_BIT 7
`define CTRL_ARM_BIT 8
`define CTRL_AUTO_BIT 9
`define CTRL_FINE_BIT 10
`define CTRL_INV_BIT 11
`define CTRL_VDC_BIT 12
// Limits and steps
`define PCT_MAX 100
`define EXT_MV_NARROW 500
`define EXT_MV_WIDE 1000
`define DLY_MAX_UNITS 2250
`define DLY_COARSE_UNITS 25
`define DLY_UNITS_PER_WINDOW 250
`define CODE_FULL 2047
`define RANGE_RESET_MV 1000
`define WINDOW_RESET 4096
// Auto trigger wait
`define AUTO_WAIT_MS 360
`define CLK_MHZ 250
`define AUTO_WAIT_CYCLES (`AUTO_WAIT_MS * 1000 * `CLK_MHZ)
`endif

// >>> include/trig_pkg.sv
// Types for the acquisition trigger control block.
// Assumes the constants header sits beside it.
package trig_pkg;
    typedef enum logic [4:0] {
        SRC_CH_A = 5'h01,
        SRC_CH_B = 5'h02,
        SRC_SUM = 5'h04,
        SRC_EXT = 5'h08,
        SRC_CAL = 5'h10
    } source_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WATCH = 3'h2,
        ST_DELAY = 3'h4
    } trig_state_type;
    typedef struct packed {
        logic vert_dc;
        logic invert;
        logic fine;
        logic mode_auto;
        logic arm_ext;
        logic units_pct;
        logic coup_ac;
        logic slope_fall;
        source_type source;
    } trig_cfg_type;
    typedef struct packed {
        logic signed [11:0] first_input_channel;
        logic signed [11:0] second_input_channel;
        logic signed [11:0] ext;
        logic signed [11:0] cal;
    } sample_set_type;
endpackage

// >>> hw/trig_ctrl.sv
// Trigger control: source, level, slope, coupling, delay and arming.
// Assumes an AHB-Lite master, sampled signals from the front end on hclk
// and the acquisition state machine supplying run state and start pulses.
`timescale 1ns/1ns
`default_nettype none
`include "trig_map.svh"

module trig_ctrl #(
    parameter bit TWO_CHANNEL = 1'b1,
    parameter int unsigned AUTO_WAIT = `AUTO_WAIT_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Sampled trigger signals
    input wire trig_pkg::sample_set_type samples,
    input wire logic sample_valid,
    // Acquisition state machine
    input wire logic acq_running,
    input wire logic acq_hold_next,
    input wire logic acq_start,
    // External arm pin
    input wire logic arm_in_n,
    // Results
    output logic storage_start,
    output logic level_tilde
);
    localparam int EXT_MV = TWO_CHANNEL ? `EXT_MV_WIDE : `EXT_MV_NARROW;

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input int lim);
        clamp = (v > lim) ? lim : ((v < -lim) ? -lim : v);
    endfunction

    function automatic logic src_ok(input logic [4:0] s);
        if (TWO_CHANNEL) begin
            src_ok = (s == trig_pkg::SRC_CH_A) || (s == trig_pkg::SRC_CH_B) || (s == trig_pkg::SRC_SUM)
                || (s == trig_pkg::SRC_EXT);
        end else begin
            src_ok = (s == trig_pkg::SRC_EXT) || (s == trig_pkg::SRC_CAL);
        end
    endfunction

    // Register state
    trig_pkg::trig_cfg_type cfg_q, cfg_d;
    logic signed [7:0] pct_q, pct_d;
    logic signed [15:0] ext_mv_q, ext_mv_d;
    logic [15:0] range_q, range_d;
    logic signed [15:0] offset_q, offset_d;
    logic [11:0] dly_q, dly_d;
    logic [23:0] window_q, window_d;
    logic [31:0] hrdata_d;
    logic wr_q, wr_d;
    logic [7:0] addr_q, addr_d;

    // Trigger state
    trig_pkg::trig_state_type state_q, state_d;
    logic [2:0] arm_sync_q;
    logic arm_latch_q, arm_latch_d;
    logic [31:0] auto_cnt_q, auto_cnt_d;
    logic [35:0] dly_cnt_q, dly_cnt_d;
    logic signed [12:0] prev_q, prev_d;
    logic start_q, start_d;

    logic internal_src, armed, acq_active, crossing, auto_fire, arm_low;
    logic signed [12:0] sig, sig_raw, thr;
    logic signed [31:0] level_mv, wval, off_term, step_val, thr_wide;
    logic [35:0] dly_cycles;

    assign internal_src = (cfg_q.source != trig_pkg::SRC_EXT);
    assign off_term = (cfg_q.vert_dc && !cfg_q.coup_ac) ? 32'(offset_q) : 32'sh0;
    assign level_mv = internal_src ? (32'(pct_q) * $signed({16'h0000, range_q})) / 100 + off_term
        : 32'(ext_mv_q);
    assign wval = $signed(hwdata);
    assign step_val = clamp($signed({20'h00000, dly_q}) + $signed(hwdata[15:0]) * (cfg_q.fine ? 1 : `DLY_COARSE_UNITS),
        `DLY_MAX_UNITS);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign level_tilde = cfg_q.coup_ac;

    // Register file
    always_comb begin
        cfg_d = cfg_q;
        pct_d = pct_q;
        ext_mv_d = ext_mv_q;
        range_d = range_q;
        offset_d = offset_q;
        dly_d = dly_q;
        window_d = window_q;
        hrdata_d = hrdata;
        wr_d = 1'b0;
        addr_d = addr_q;
        if (hsel && hready && htrans[1]) begin
            wr_d = hwrite;
            addr_d = haddr[7:0];
            unique case (haddr[7:0])
                `TRIG_CTRL_OFS: hrdata_d = {19'h0, cfg_q};
                `TRIG_LEVEL_OFS: hrdata_d = internal_src && cfg_q.units_pct ? 32'(pct_q) : level_mv;
                `TRIG_RANGE_OFS: hrdata_d = {16'h0000, range_q};
                `TRIG_OFFSET_OFS: hrdata_d = 32'(offset_q);
                `TRIG_DELAY_OFS: hrdata_d = {20'h00000, dly_q};
                `TRIG_WINDOW_OFS: hrdata_d = {8'h00, window_q};
                `TRIG_READOUT_OFS: hrdata_d = level_mv;
                `TRIG_STATUS_OFS: hrdata_d = {25'h0, start_q, arm_latch_q, armed, level_tilde, state_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_q) begin
            unique case (addr_q)
                `TRIG_CTRL_OFS: begin
                    cfg_d.slope_fall = hwdata[`CTRL_SLOPE_BIT];
                    cfg_d.arm_ext = hwdata[`CTRL_ARM_BIT];
                    cfg_d.mode_auto = hwdata[`CTRL_AUTO_BIT];
                    cfg_d.fine = hwdata[`CTRL_FINE_BIT];
                    cfg_d.invert = hwdata[`CTRL_INV_BIT];
                    cfg_d.vert_dc = hwdata[`CTRL_VDC_BIT];
                    if (src_ok(hwdata[`CTRL_SRC_LSB +: 5])) begin
                        cfg_d.source = trig_pkg::source_type'(hwdata[`CTRL_SRC_LSB +: 5]);
                    end
                    if (cfg_d.source != trig_pkg::SRC_EXT) begin
                        cfg_d.units_pct = hwdata[`CTRL_UNIT_BIT];
                        cfg_d.coup_ac = TWO_CHANNEL ? hwdata[`CTRL_COUP_BIT] : 1'b1;
                    end
                    if (cfg_d.source == trig_pkg::SRC_EXT) begin
                        cfg_d.units_pct = 1'b0;
                        cfg_d.coup_ac = 1'b1;
                    end
                end
                `TRIG_LEVEL_OFS: begin
                    if (!internal_src) begin
                        ext_mv_d = 16'(clamp(wval, EXT_MV));
                    end else if (cfg_q.units_pct) begin
                        pct_d = 8'(clamp(wval, `PCT_MAX));
                    end else if (range_q != 16'h0000) begin
                        pct_d = 8'(clamp(((wval - off_term) * 100) / $signed({16'h0000, range_q}), `PCT_MAX));
                    end
                end
                `TRIG_RANGE_OFS: range_d = hwdata[15:0];
                `TRIG_OFFSET_OFS: offset_d = hwdata[15:0];
                `TRIG_DELAY_OFS: dly_d = 12'(clamp(wval, `DLY_MAX_UNITS) < 0 ? 0 : clamp(wval, `DLY_MAX_UNITS));
                `TRIG_STEP_OFS: begin
                    dly_d = (step_val < 0) ? 12'h000 : 12'(step_val);
                end
                `TRIG_WINDOW_OFS: window_d = hwdata[23:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= '{vert_dc: 1'b1, invert: 1'b0, fine: 1'b0, mode_auto: 1'b1, arm_ext: 1'b0, units_pct: 1'b0,
                coup_ac: !TWO_CHANNEL, slope_fall: 1'b0,
                source: TWO_CHANNEL ? trig_pkg::SRC_CH_A : trig_pkg::SRC_EXT};
            pct_q <= 8'h00;
            ext_mv_q <= 16'h0000;
            range_q <= 16'(`RANGE_RESET_MV);
            offset_q <= 16'h0000;
            dly_q <= 12'h000;
            window_q <= 24'(`WINDOW_RESET);
            hrdata <= 32'h0000_0000;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            pct_q <= pct_d;
            ext_mv_q <= ext_mv_d;
            range_q <= range_d;
            offset_q <= offset_d;
            dly_q <= dly_d;
            window_q <= window_d;
            hrdata <= hrdata_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
        end
    end

    // Trigger source selection
    always_comb begin
        sig_raw = 13'sh0;
        unique case (cfg_q.source)
            trig_pkg::SRC_CH_A: sig_raw = 13'(samples.first_input_channel);
            trig_pkg::SRC_CH_B: sig_raw = 13'(samples.second_input_channel);
            trig_pkg::SRC_SUM: sig_raw = 13'(samples.first_input_channel) + 13'(samples.second_input_channel);
            trig_pkg::SRC_EXT: sig_raw = 13'(samples.ext);
            trig_pkg::SRC_CAL: sig_raw = 13'(samples.cal);
            default: sig_raw = 13'sh0;
        endcase
    end

    // Only vertical channels invert; slope and level settings stay untouched
    assign sig = (TWO_CHANNEL && internal_src && cfg_q.invert) ? -sig_raw : sig_raw;
    // Comparing in sample codes keeps the level fixed in the window when range moves
    assign thr_wide = internal_src ? (32'(pct_q) * `CODE_FULL) / `PCT_MAX
        : (32'(ext_mv_q) * `CODE_FULL) / EXT_MV;
    assign thr = 13'(thr_wide);
    assign crossing = sample_valid && (cfg_q.slope_fall ? (prev_q > thr && sig <= thr)
        : (prev_q < thr && sig >= thr));
    assign dly_cycles = ({24'h000000, dly_q} * {12'h000, window_q}) / 36'(`DLY_UNITS_PER_WINDOW);

    // Arming: a level counts only once the last two sync stages agree
    assign arm_low = !arm_sync_q[1] && !arm_sync_q[2];
    assign acq_active = acq_running || acq_hold_next;
    assign armed = (!cfg_q.arm_ext || cfg_q.mode_auto) ? 1'b1 : arm_latch_q;
    assign auto_fire = cfg_q.mode_auto && (auto_cnt_q == 32'(AUTO_WAIT - 1));
    assign storage_start = start_q;

    always_comb begin
        state_d = state_q;
        arm_latch_d = arm_latch_q;
        auto_cnt_d = auto_cnt_q;
        dly_cnt_d = dly_cnt_q;
        prev_d = sample_valid ? sig : prev_q;
        start_d = 1'b0;
        unique case (state_q)
            trig_pkg::ST_IDLE: begin
                if (acq_start) begin
                    state_d = trig_pkg::ST_WATCH;
                    auto_cnt_d = 32'h0000_0000;
                end
            end
            trig_pkg::ST_WATCH: begin
                auto_cnt_d = acq_start ? 32'h0000_0000 : auto_cnt_q + 32'h0000_0001;
                if (!acq_active) begin
                    state_d = trig_pkg::ST_IDLE;
                end else if ((crossing && armed) || auto_fire) begin
                    state_d = trig_pkg::ST_DELAY;
                    dly_cnt_d = dly_cycles;
                    arm_latch_d = 1'b0;
                end
            end
            trig_pkg::ST_DELAY: begin
                if (dly_cnt_q == 36'h0_0000_0000) begin
                    state_d = trig_pkg::ST_IDLE;
                    start_d = 1'b1;
                end else begin
                    dly_cnt_d = dly_cnt_q - 36'h0_0000_0001;
                end
            end
            default: state_d = trig_pkg::ST_IDLE;
        endcase
        // Set wins over the clear, so a pin held low rearms at once
        if (arm_low && acq_active) begin
            arm_latch_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= trig_pkg::ST_IDLE;
            arm_sync_q <= 3'h7;
            arm_latch_q <= 1'b0;
            auto_cnt_q <= 32'h0000_0000;
            dly_cnt_q <= 36'h0_0000_0000;
            prev_q <= 13'sh0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            arm_sync_q <= {arm_sync_q[1:0], arm_in_n};
            arm_latch_q <= arm_latch_d;
            auto_cnt_q <= auto_cnt_d;
            dly_cnt_q <= dly_cnt_d;
            prev_q <= prev_d;
            start_q <= start_d;
        end
    end

    // Checks on the block's own state
    source_legal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        src_ok(cfg_q.source))
        else $error("trigger source outside the variant's set");
    ext_units_volt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_q.source == trig_pkg::SRC_EXT) |-> !cfg_q.units_pct)
        else $error("external source left in percent units");
    ext_coupling_ac_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_q.source == trig_pkg::SRC_EXT) |-> cfg_q.coup_ac)
        else $error("external source left in DC coupling");
    pct_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pct_q >= -`PCT_MAX) && (pct_q <= `PCT_MAX))
        else $error("percent level out of range");
    delay_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dly_q <= `DLY_MAX_UNITS)
        else $error("delay beyond nine windows");
    ext_arm_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == trig_pkg::ST_WATCH && state_d == trig_pkg::ST_DELAY && cfg_q.arm_ext && !cfg_q.mode_auto)
        |-> arm_latch_q)
        else $error("trigger taken without external arm");
    start_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_q |=> !start_q)
        else $error("storage start longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/acq_model.sv
// Model of the acquisition state machine beside the trigger block.
// Assumes the bench calls begin_acq just after a rising hclk edge.
`timescale 1ns/1ns
`default_nettype none
module acq_model (
    // Clock and trigger result
    input wire logic hclk,
    input wire logic storage_start,
    // Acquisition state
    output logic acq_running,
    output logic acq_hold_next,
    output logic acq_start
);
    initial begin
        acq_running = 1'b0;
        acq_hold_next = 1'b0;
        acq_start = 1'b0;
    end
    // Storage ends the sequence, so recognition stops until a restart
    always @(posedge hclk) begin
        if (storage_start === 1'b1) acq_running <= 1'b0;
    end
    task begin_acq();
        acq_running <= 1'b1;
        acq_start <= 1'b1;
        @(posedge hclk);
        acq_start <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the trigger control block.
// Assumes trig_ctrl, acq_model and the trig package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int WAIT = 40;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sample_valid, arm_in_n;
    logic acq_running, acq_hold_next, acq_start, storage_start, level_tilde;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    trig_pkg::sample_set_type samples;
    int fail_count, tests_run, first;
    trig_ctrl #(.TWO_CHANNEL(1'b1), .AUTO_WAIT(WAIT)) u_trig_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .samples(samples), .sample_valid(sample_valid), .acq_running(acq_running),
        .acq_hold_next(acq_hold_next), .acq_start(acq_start), .arm_in_n(arm_in_n),
        .storage_start(storage_start), .level_tilde(level_tilde));
    acq_model u_acq_model (.hclk(hclk), .storage_start(storage_start), .acq_running(acq_running),
        .acq_hold_next(acq_hold_next), .acq_start(acq_start));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test();
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 199);
        rd = hrdata;
    endtask
    // Settle the input first so a jump before the start is not a crossing
    task run(input int dir, input int n, input logic [1:0] arm);
        samples.first_input_channel <= 12'(-200 * dir);
        repeat (4) @(posedge hclk);
        u_acq_model.begin_acq();
        first = -1;
        for (int i = 0; i < n; i++) begin
            if (i < 4) arm_in_n <= arm[i / 2];
            samples.first_input_channel <= 12'(dir * (i < 8 ? i * 50 - 200 : 200));
            @(negedge hclk);
            if (storage_start === 1'b1 && first < 0) first = i;
            @(posedge hclk);
        end
    endtask
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        samples = '0;
        sample_valid = 1'b1;
        arm_in_n = 1'b1;
        fail_count = 0;
        tests_run = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h0, 32'h0);
        check(rd & 32'h1FF, 32'h1);
        ahb(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, 32'h4, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, 32'hC, 32'h64);
        ahb(1'b0, 32'h1C, 32'h0);
        check(rd, 32'h64);
        ahb(1'b1, 32'h14, 32'h1);
        ahb(1'b0, 32'h10, 32'h0);
        check(rd, 32'h19);
        ahb(1'b1, 32'h10, 32'h0);
        ahb(1'b1, 32'h0, 32'h88);
        ahb(1'b0, 32'h0, 32'h0);
        check(rd & 32'hFF, 32'h48);
        check(level_tilde, 1'b1);
        ahb(1'b1, 32'h0, 32'h81);
        ahb(1'b0, 32'h0, 32'h0);
        check(rd & 32'hC0, 32'h80);
        ahb(1'b1, 32'h0, 32'h1);
        ahb(1'b0, 32'h0, 32'h0);
        check(level_tilde, 1'b0);
        run(1, 30, 2'b11);
        check(first >= 0, 1'b1);
        ahb(1'b1, 32'h0, 32'h21);
        run(1, 30, 2'b11);
        check(first < 0, 1'b1);
        run(-1, 30, 2'b11);
        check(first >= 0, 1'b1);
        ahb(1'b1, 32'h0, 32'h801);
        run(1, 30, 2'b11);
        check(first < 0, 1'b1);
        run(-1, 30, 2'b11);
        check(first >= 0, 1'b1);
        ahb(1'b1, 32'h0, 32'h101);
        run(1, 30, 2'b11);
        check(first < 0, 1'b1);
        run(1, 30, 2'b10);
        check(first >= 0, 1'b1);
        run(1, 30, 2'b00);
        check(first >= 0, 1'b1);
        run(1, 30, 2'b00);
        check(first >= 0, 1'b1);
        ahb(1'b1, 32'h0, 32'h301);
        run(0, WAIT + 30, 2'b11);
        check(first >= WAIT - 8 && first <= WAIT + 20, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
